/* File: rtl/sleep_pkg.sv */
`default_nettype none
package sleep_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam int CTRL_ARM_BIT = 7;
	localparam int CTRL_SEL_HI = 6;
	localparam int CTRL_SEL_LO = 4;
	localparam int CTRL_EXT_IRQ_ONE_HI = 3;
	localparam int CTRL_EXT_IRQ_ONE_LO = 2;
	localparam int CTRL_EXT_IRQ_ZERO_HI = 1;
	localparam int CTRL_EXT_IRQ_ZERO_LO = 0;
	localparam logic [1:0] SENSE_LOW_LEVEL = 2'h0;
	localparam int STAT_STATE_LO = 0;
	localparam int STAT_MODE_LO = 4;
	localparam int STAT_RESET_WAKE_BIT = 7;

	// ----------------------------------------
	// Modes and states
	// ----------------------------------------
	typedef enum logic [2:0] {
		MODE_IDLE = 3'h0,
		MODE_ADC_NR = 3'h1,
		MODE_POWER_DOWN = 3'h2,
		MODE_POWER_SAVE = 3'h3,
		MODE_RSVD_4 = 3'h4,
		MODE_RSVD_5 = 3'h5,
		MODE_STANDBY = 3'h6,
		MODE_EXT_STANDBY = 3'h7
	} sleep_mode_e;

	typedef enum logic [3:0] {
		ST_ACTIVE = 4'h1,
		ST_ASLEEP = 4'h2,
		ST_STARTUP = 4'h4,
		ST_HOLD = 4'h8
	} sleep_state_e;

	// ----------------------------------------
	// Timing, in clock cycles
	// ----------------------------------------
	localparam int COUNT_W = 16;
	localparam logic [COUNT_W-1:0] HOLD_CYCLES = 16'h0004;
	localparam logic [COUNT_W-1:0] SHORT_STARTUP_CYCLES = 16'h0006;
	localparam logic [COUNT_W-1:0] NO_STARTUP_CYCLES = 16'h0000;
	localparam logic [3:0] FUSE_CRYSTAL_MIN = 4'h9;

	// ----------------------------------------
	// Wake source and clock domain positions
	// ----------------------------------------
	localparam int WAKE_ADC = 0;
	localparam int WAKE_TWI = 1;
	localparam int WAKE_ASYNC_TIMER = 2;
	localparam int WAKE_SPM_EE = 3;
	localparam int WAKE_EXT_LEVEL = 4;
	localparam int WAKE_EXT_TWO = 5;
	localparam int WAKE_OTHER = 6;
	localparam int WAKE_NUM = 7;
	localparam int DOM_CPU = 0;
	localparam int DOM_FLASH = 1;
	localparam int DOM_IO = 2;
	localparam int DOM_ADC = 3;
	localparam int DOM_ASY = 4;
	localparam int DOM_MAIN_OSC = 5;
	localparam int DOM_TIMER_OSC = 6;
	localparam int DOM_NUM = 7;

endpackage
`default_nettype wire

/* File: rtl/sleep_link_if.sv */
`default_nettype none
interface sleep_link_if;
	sleep_pkg::sleep_mode_e mode;
	logic [sleep_pkg::WAKE_NUM-1:0] sources;
	logic wake;
	logic load;
	logic [sleep_pkg::COUNT_W-1:0] cycles;
	logic done;

	modport ctrl (output mode, sources, load, cycles, input wake, done);
	modport qual (input mode, sources, output wake);
	modport timer (input load, cycles, output done);
endinterface
`default_nettype wire

/* File: rtl/wake_qualifier.sv */
`default_nettype none
module wake_qualifier (
	sleep_link_if.qual link
);
	// ----------------------------------------
	// Sources allowed to end each mode
	// ----------------------------------------
	function automatic logic [sleep_pkg::WAKE_NUM-1:0] allowed(input sleep_pkg::sleep_mode_e m);
		logic [sleep_pkg::WAKE_NUM-1:0] a;
		a = '0;
		unique case (m)
			sleep_pkg::MODE_IDLE: begin
				a = '1;
			end
			sleep_pkg::MODE_ADC_NR: begin
				a = '1;
				a[sleep_pkg::WAKE_OTHER] = 1'b0;
			end
			sleep_pkg::MODE_POWER_DOWN, sleep_pkg::MODE_STANDBY: begin
				a[sleep_pkg::WAKE_TWI] = 1'b1;
				a[sleep_pkg::WAKE_EXT_LEVEL] = 1'b1;
				a[sleep_pkg::WAKE_EXT_TWO] = 1'b1;
			end
			sleep_pkg::MODE_POWER_SAVE, sleep_pkg::MODE_EXT_STANDBY: begin
				a[sleep_pkg::WAKE_TWI] = 1'b1;
				a[sleep_pkg::WAKE_EXT_LEVEL] = 1'b1;
				a[sleep_pkg::WAKE_EXT_TWO] = 1'b1;
				a[sleep_pkg::WAKE_ASYNC_TIMER] = 1'b1;
			end
			default: begin
				a = '0;
			end
		endcase
		return a;
	endfunction

	always_comb begin
		link.wake = |(link.sources & allowed(link.mode));
	end
endmodule
`default_nettype wire

/* File: rtl/startup_timer.sv */
`default_nettype none
module startup_timer (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Control
	sleep_link_if.timer link
);
	logic [sleep_pkg::COUNT_W-1:0] count;
	logic [sleep_pkg::COUNT_W-1:0] next_count;

	// ----------------------------------------
	// Down counter, done on its last cycle
	// ----------------------------------------
	always_comb begin
		next_count = count;
		if (link.load) begin
			next_count = link.cycles;
		end else if (count != '0) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	assign link.done = (count == {{(sleep_pkg::COUNT_W-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

/* File: rtl/sleep_mode_controller.sv */
// Behaviour
// - Sleep only when armed at sleep instruction
// - Select bits 6..4 choose one of six modes
// - Standby modes need crystal clock source
// - Hold core four cycles after start-up
// - Register file and SRAM kept unchanged
// - Reset while asleep restarts at reset vector
// - Control register layout, all RW, reset zero
// - Idle stops CPU and flash clocks only
// - Idle wakes on external and internal interrupts
// - Idle or noise mode starts ADC conversion
// - Noise mode stops I/O, CPU, flash clocks
// - Noise mode wakes only on listed events
// - Power-down stops oscillator and generated clocks
// - Power-down wakes on reset, TWI, level, EXT_IRQ_TWO
// - Power-down wake waits fuse start-up delay
// - Power-save adds asynchronous timer when selected
// - Power-save timer wake needs enables set
// - Standby modes keep oscillator, six-cycle wake
//
// The address map and the APB interface to the registers were decided locally.
`default_nettype none
module sleep_mode_controller #(
	parameter logic [sleep_pkg::COUNT_W-1:0] CRYSTAL_STARTUP_CYCLES = 16'h0400
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// APB slave
	input wire logic [sleep_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core
	input wire logic sleep_exec,
	input wire logic reset_request,
	input wire logic global_irq_enable,
	output logic core_halt,
	output logic core_resume,
	output logic core_restart_vector,
	// Wake sources from same-clock logic
	input wire logic adc_enabled,
	input wire logic adc_done,
	input wire logic twi_address_match,
	input wire logic spm_ee_ready,
	input wire logic other_irq,
	input wire logic async_timer_clock_select,
	input wire logic async_timer_overflow,
	input wire logic async_timer_compare,
	input wire logic async_overflow_irq_en,
	input wire logic async_compare_irq_en,
	input wire logic ext_irq_zero_en,
	input wire logic ext_irq_one_en,
	input wire logic ext_irq_two_flag,
	// Pins and fuses
	input wire logic ext_irq_zero,
	input wire logic ext_irq_one,
	input wire logic [3:0] clock_source_fuses,
	// Clock domains and ADC
	output logic [sleep_pkg::DOM_NUM-1:0] clk_domain_en,
	output logic adc_start
);
	sleep_link_if link ();

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic crystal_source(input logic [3:0] fuses);
		return fuses >= sleep_pkg::FUSE_CRYSTAL_MIN;
	endfunction

	function automatic logic mode_usable(input logic [2:0] sel, input logic crystal);
		logic ok;
		ok = 1'b0;
		unique case (sleep_pkg::sleep_mode_e'(sel))
			sleep_pkg::MODE_IDLE, sleep_pkg::MODE_ADC_NR: begin
				ok = 1'b1;
			end
			sleep_pkg::MODE_POWER_DOWN, sleep_pkg::MODE_POWER_SAVE: begin
				ok = 1'b1;
			end
			sleep_pkg::MODE_STANDBY, sleep_pkg::MODE_EXT_STANDBY: begin
				ok = crystal;
			end
			default: begin
				ok = 1'b0;
			end
		endcase
		return ok;
	endfunction

	function automatic logic [sleep_pkg::COUNT_W-1:0] startup_for(
		input sleep_pkg::sleep_mode_e m, input logic crystal
	);
		logic [sleep_pkg::COUNT_W-1:0] c;
		c = sleep_pkg::NO_STARTUP_CYCLES;
		unique case (m)
			sleep_pkg::MODE_POWER_DOWN, sleep_pkg::MODE_POWER_SAVE: begin
				// Same delay as the reset time-out for this source
				c = crystal ? CRYSTAL_STARTUP_CYCLES : sleep_pkg::SHORT_STARTUP_CYCLES;
			end
			sleep_pkg::MODE_STANDBY, sleep_pkg::MODE_EXT_STANDBY: begin
				c = sleep_pkg::SHORT_STARTUP_CYCLES;
			end
			default: begin
				c = sleep_pkg::NO_STARTUP_CYCLES;
			end
		endcase
		return c;
	endfunction

	function automatic logic [sleep_pkg::DOM_NUM-1:0] domains(
		input sleep_pkg::sleep_state_e s, input sleep_pkg::sleep_mode_e m, input logic as_sel
	);
		logic [sleep_pkg::DOM_NUM-1:0] d;
		logic idle;
		logic nr;
		logic save;
		d = '0;
		idle = (m == sleep_pkg::MODE_IDLE);
		nr = (m == sleep_pkg::MODE_ADC_NR);
		save = (m == sleep_pkg::MODE_POWER_SAVE) || (m == sleep_pkg::MODE_EXT_STANDBY);
		if (s == sleep_pkg::ST_ACTIVE) begin
			d = '1;
			d[sleep_pkg::DOM_TIMER_OSC] = as_sel;
		end else begin
			// CPU and flash stay off until the core is released
			d[sleep_pkg::DOM_IO] = idle;
			d[sleep_pkg::DOM_ADC] = idle || nr;
			d[sleep_pkg::DOM_ASY] = idle || nr || (save && as_sel);
			d[sleep_pkg::DOM_MAIN_OSC] = idle || nr || m[2];
			d[sleep_pkg::DOM_TIMER_OSC] = as_sel && (idle || nr || save);
			if (s == sleep_pkg::ST_STARTUP) begin
				d[sleep_pkg::DOM_MAIN_OSC] = 1'b1;
			end
			if (s == sleep_pkg::ST_HOLD) begin
				d[sleep_pkg::DOM_IO] = 1'b1;
				d[sleep_pkg::DOM_ADC] = 1'b1;
				d[sleep_pkg::DOM_ASY] = 1'b1;
				d[sleep_pkg::DOM_MAIN_OSC] = 1'b1;
			end
		end
		return d;
	endfunction

	// ----------------------------------------
	// Pin and fuse synchronisers
	// ----------------------------------------
	logic [5:0] pin_meta;
	logic [5:0] pin_sync;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_meta <= 6'h3F;
			pin_sync <= 6'h3F;
		end else begin
			pin_meta <= {clock_source_fuses, ext_irq_one, ext_irq_zero};
			pin_sync <= pin_meta;
		end
	end

	logic ext_irq_zero_level;
	logic ext_irq_one_level;
	logic [3:0] fuses;
	logic crystal;
	assign ext_irq_zero_level = pin_sync[0];
	assign ext_irq_one_level = pin_sync[1];
	assign fuses = pin_sync[5:2];
	assign crystal = crystal_source(fuses);

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	logic [7:0] mcu_sleep_control;
	logic [7:0] next_control;
	logic wr_access;
	logic setup_phase;
	logic sleep_arm;
	logic [2:0] sleep_select;

	assign setup_phase = psel && !penable;
	assign wr_access = psel && penable && pready && pwrite;
	assign sleep_arm = mcu_sleep_control[sleep_pkg::CTRL_ARM_BIT];
	assign sleep_select = mcu_sleep_control[sleep_pkg::CTRL_SEL_HI:sleep_pkg::CTRL_SEL_LO];

	always_comb begin
		next_control = mcu_sleep_control;
		// Only software writes change any bit, the arm bit included
		if (wr_access && paddr == sleep_pkg::ADDR_CONTROL) begin
			next_control = pwdata[7:0];
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mcu_sleep_control <= sleep_pkg::CONTROL_RESET;
		end else begin
			mcu_sleep_control <= next_control;
		end
	end

	// ----------------------------------------
	// Wake source gathering
	// ----------------------------------------
	logic level0_wake;
	logic level1_wake;
	logic async_wake;

	always_comb begin
		level0_wake = ext_irq_zero_en && !ext_irq_zero_level &&
			(mcu_sleep_control[sleep_pkg::CTRL_EXT_IRQ_ZERO_HI:sleep_pkg::CTRL_EXT_IRQ_ZERO_LO] == sleep_pkg::SENSE_LOW_LEVEL);
		level1_wake = ext_irq_one_en && !ext_irq_one_level &&
			(mcu_sleep_control[sleep_pkg::CTRL_EXT_IRQ_ONE_HI:sleep_pkg::CTRL_EXT_IRQ_ONE_LO] == sleep_pkg::SENSE_LOW_LEVEL);
		async_wake = async_timer_clock_select && global_irq_enable &&
			((async_timer_overflow && async_overflow_irq_en) ||
			(async_timer_compare && async_compare_irq_en));
		link.sources = '0;
		link.sources[sleep_pkg::WAKE_ADC] = adc_done;
		link.sources[sleep_pkg::WAKE_TWI] = twi_address_match;
		link.sources[sleep_pkg::WAKE_ASYNC_TIMER] = async_wake;
		link.sources[sleep_pkg::WAKE_SPM_EE] = spm_ee_ready;
		link.sources[sleep_pkg::WAKE_EXT_LEVEL] = level0_wake || level1_wake;
		link.sources[sleep_pkg::WAKE_EXT_TWO] = ext_irq_two_flag;
		link.sources[sleep_pkg::WAKE_OTHER] = other_irq;
	end

	wake_qualifier u_qualifier (
		.link(link)
	);

	startup_timer u_timer (
		.clock(clock),
		.rst(rst),
		.link(link)
	);

	// ----------------------------------------
	// Sleep sequencer
	// ----------------------------------------
	sleep_pkg::sleep_state_e state;
	sleep_pkg::sleep_state_e next_state;
	sleep_pkg::sleep_mode_e mode;
	sleep_pkg::sleep_mode_e next_mode;
	logic reset_wake;
	logic next_reset_wake;
	logic next_resume;
	logic next_restart;
	logic next_adc_start;
	logic [sleep_pkg::COUNT_W-1:0] delay;

	assign link.mode = mode;

	always_comb begin
		next_state = state;
		next_mode = mode;
		next_reset_wake = reset_wake;
		next_resume = 1'b0;
		next_restart = 1'b0;
		next_adc_start = 1'b0;
		link.load = 1'b0;
		link.cycles = sleep_pkg::HOLD_CYCLES;
		delay = startup_for(mode, crystal);
		unique case (state)
			sleep_pkg::ST_ACTIVE: begin
				next_reset_wake = 1'b0;
				if (sleep_exec && sleep_arm && mode_usable(sleep_select, crystal)) begin
					next_state = sleep_pkg::ST_ASLEEP;
					next_mode = sleep_pkg::sleep_mode_e'(sleep_select);
					next_adc_start = adc_enabled && !sleep_select[2] && !sleep_select[1];
				end
			end
			sleep_pkg::ST_ASLEEP: begin
				if (reset_request || link.wake) begin
					next_reset_wake = reset_request;
					link.load = 1'b1;
					if (delay != sleep_pkg::NO_STARTUP_CYCLES) begin
						link.cycles = delay;
						next_state = sleep_pkg::ST_STARTUP;
					end else begin
						next_state = sleep_pkg::ST_HOLD;
					end
				end
			end
			sleep_pkg::ST_STARTUP: begin
				next_reset_wake = reset_wake || reset_request;
				if (link.done) begin
					link.load = 1'b1;
					next_state = sleep_pkg::ST_HOLD;
				end
			end
			sleep_pkg::ST_HOLD: begin
				next_reset_wake = reset_wake || reset_request;
				if (link.done) begin
					next_state = sleep_pkg::ST_ACTIVE;
					next_restart = reset_wake || reset_request;
					next_resume = !(reset_wake || reset_request);
				end
			end
			default: begin
				next_state = sleep_pkg::ST_ACTIVE;
			end
		endcase
	end

	// Halting the core only stops its clocks; no storage is touched
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= sleep_pkg::ST_ACTIVE;
			mode <= sleep_pkg::MODE_IDLE;
			reset_wake <= 1'b0;
			core_halt <= 1'b0;
			core_resume <= 1'b0;
			core_restart_vector <= 1'b0;
			adc_start <= 1'b0;
			clk_domain_en <= '1;
		end else begin
			state <= next_state;
			mode <= next_mode;
			reset_wake <= next_reset_wake;
			core_halt <= (next_state != sleep_pkg::ST_ACTIVE);
			core_resume <= next_resume;
			core_restart_vector <= next_restart;
			adc_start <= next_adc_start;
			clk_domain_en <= domains(next_state, next_mode, async_timer_clock_select);
		end
	end

	// ----------------------------------------
	// APB read path
	// ----------------------------------------
	logic [31:0] next_prdata;
	logic next_slverr;
	logic [7:0] status;

	always_comb begin
		status = '0;
		status[sleep_pkg::STAT_STATE_LO +: 4] = state;
		status[sleep_pkg::STAT_MODE_LO +: 3] = mode;
		status[sleep_pkg::STAT_RESET_WAKE_BIT] = reset_wake;
		next_prdata = '0;
		next_slverr = 1'b0;
		if (setup_phase) begin
			unique case (paddr)
				sleep_pkg::ADDR_CONTROL: begin
					next_prdata = {24'h000000, mcu_sleep_control};
				end
				sleep_pkg::ADDR_STATUS: begin
					next_prdata = {24'h000000, status};
					next_slverr = pwrite;
				end
				default: begin
					next_slverr = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pready <= setup_phase;
			pslverr <= next_slverr;
		end
	end
endmodule
`default_nettype wire

/* File: sim/sleep_mode_controller_chk.sv */
`default_nettype none
module sleep_mode_controller_chk (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Register bus
	input wire logic [sleep_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	// Core and clocks
	input wire logic sleep_exec,
	input wire logic adc_enabled,
	input wire logic core_halt,
	input wire logic core_resume,
	input wire logic core_restart_vector,
	input wire logic [sleep_pkg::DOM_NUM-1:0] clk_domain_en,
	input wire logic adc_start
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	apb_ready_a: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	unmapped_err_a: assert property (psel && !penable && paddr != sleep_pkg::ADDR_CONTROL
		&& paddr != sleep_pkg::ADDR_STATUS |=> pslverr)
		else $error("unmapped access not refused");
	control_ok_a: assert property (psel && !penable && paddr == sleep_pkg::ADDR_CONTROL |=> !pslverr)
		else $error("control access refused");
	halt_cause_a: assert property ($rose(core_halt) |-> $past(sleep_exec))
		else $error("halt without sleep");
	cpu_stop_a: assert property ($rose(core_halt) |-> !clk_domain_en[sleep_pkg::DOM_CPU]
		&& !clk_domain_en[sleep_pkg::DOM_FLASH])
		else $error("cpu clocks left running");
	hold_four_a: assert property (core_resume |-> !core_halt && $past(core_halt, 5))
		else $error("resume without hold");
	clocks_back_a: assert property (core_resume |-> clk_domain_en[sleep_pkg::DOM_CPU])
		else $error("resume with cpu clock off");
	restart_kind_a: assert property (core_restart_vector |-> $past(core_halt) && !core_resume)
		else $error("bad restart pulse");
	adc_kick_a: assert property (adc_start |-> $rose(core_halt) && $past(adc_enabled))
		else $error("stray conversion start");
	resume_c: cover property (core_resume);
	restart_c: cover property (core_restart_vector);
	adc_c: cover property (adc_start);
endmodule
bind sleep_mode_controller sleep_mode_controller_chk u_chk (.clock, .rst, .paddr, .psel, .penable, .pwrite,
	.pready, .pslverr, .sleep_exec, .adc_enabled, .core_halt, .core_resume, .core_restart_vector,
	.clk_domain_en, .adc_start);
`default_nettype wire

/* File: sim/core_model.sv */
`default_nettype none
module core_model (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Bench request
	input wire logic go,
	// Controller side
	input wire logic core_halt,
	output logic sleep_exec
);
	timeunit 1ns;
	timeprecision 100ps;
	// Sleep instruction only issued while the core runs
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sleep_exec <= 1'b0;
		end else begin
			sleep_exec <= go && !core_halt;
		end
	end
endmodule
`default_nettype wire

/* File: sim/sleep_mode_controller_test.sv */
`default_nettype none
module sleep_mode_controller_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, go = 1'b0, sleep_exec, core_halt, core_resume, core_restart_vector, adc_start;
	logic global_irq_enable = 1'b1;
	logic adc_en = 1'b1;
	logic as_sel = 1'b0;
	logic [7:0] src = 8'h00;
	logic [3:0] fuses = 4'h9;
	logic [6:0] clk_domain_en;
	logic [31:0] rd;
	logic err, rv;
	int bad_count = 0;
	int comparisons = 0;
	int n, i;
	logic [7:0] rf_ctl[5] = '{8'h20, 8'hC0, 8'hD0, 8'hE0, 8'hF0};
	logic [3:0] rf_fuse[5] = '{4'h9, 4'h9, 4'h9, 4'h1, 4'h1};
	logic [2:0] md_sel[7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7, 3'h2};
	logic [3:0] md_fuse[7] = '{4'h9, 4'h9, 4'h9, 4'h9, 4'h9, 4'h9, 4'h1};
	logic md_as[7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
	logic [6:0] md_mask[7] = '{7'h3C, 7'h38, 7'h00, 7'h50, 7'h20, 7'h70, 7'h00};
	int md_src[7] = '{2, 0, 1, 3, 4, 1, 1};
	int md_d[7] = '{0, 0, 8, 8, 6, 6, 6};

	always #2 clock = ~clock;

	core_model u_core (.clock(clock), .rst(rst), .go(go), .core_halt(core_halt), .sleep_exec(sleep_exec));

	sleep_mode_controller #(.CRYSTAL_STARTUP_CYCLES(16'h0008)) u_dut (.clock(clock), .rst(rst),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sleep_exec(sleep_exec), .reset_request(src[7]),
		.global_irq_enable(global_irq_enable), .core_halt(core_halt), .core_resume(core_resume),
		.core_restart_vector(core_restart_vector), .adc_enabled(adc_en), .adc_done(src[0]),
		.twi_address_match(src[1]), .spm_ee_ready(src[5]), .other_irq(src[2]),
		.async_timer_clock_select(as_sel), .async_timer_overflow(src[3]), .async_timer_compare(src[3]),
		.async_overflow_irq_en(as_sel), .async_compare_irq_en(as_sel), .ext_irq_zero_en(1'b1),
		.ext_irq_one_en(1'b0), .ext_irq_two_flag(src[4]), .ext_irq_zero(!src[6]), .ext_irq_one(1'b1),
		.clock_source_fuses(fuses), .clk_domain_en(clk_domain_en), .adc_start(adc_start));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) bad_count++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic sleep_now();
		@(posedge clock);
		go <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
		repeat (2) @(posedge clock);
	endtask

	// Raise one source, count edges until resume or restart shows
	task automatic wake(input int idx, output int cnt, output logic kind);
		@(posedge clock);
		src[idx] <= 1'b1;
		cnt = 0;
		do begin
			@(posedge clock);
			cnt++;
		end while (core_resume !== 1'b1 && core_restart_vector !== 1'b1 && cnt < 100);
		if (cnt >= 100) bad_count++;
		kind = core_restart_vector;
		src <= 8'h00;
	endtask

	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge clock);
		bad_count++;
		wrap_up();
	end

	initial begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		apb(1'b0, sleep_pkg::ADDR_CONTROL, 32'h0);
		check(rd, 32'h0);
		apb(1'b1, sleep_pkg::ADDR_CONTROL, 32'hFFFF_FF5A);
		apb(1'b0, sleep_pkg::ADDR_CONTROL, 32'h0);
		check(rd, 32'h5A);
		apb(1'b0, 8'h08, 32'h0);
		check({rd[30:0], err}, 32'h1);
		apb(1'b1, sleep_pkg::ADDR_STATUS, 32'hFF);
		check(err, 1'b1);
		$display("test registers done");
		for (i = 0; i < 5; i++) begin
			fuses <= rf_fuse[i];
			apb(1'b1, sleep_pkg::ADDR_CONTROL, {24'h0, rf_ctl[i]});
			sleep_now();
			check(core_halt, 1'b0);
		end
		$display("test refusals done");
		for (i = 0; i < 7; i++) begin
			fuses <= md_fuse[i];
			as_sel <= md_as[i];
			// ADC left off for the noise mode run: no conversion start expected there
			adc_en <= (i != 1);
			apb(1'b1, sleep_pkg::ADDR_CONTROL, {24'h0, 1'b1, md_sel[i], 4'h0});
			sleep_now();
			check({core_halt, adc_start, clk_domain_en}, {1'b1, md_sel[i] < 3'h2 && i != 1, md_mask[i]});
			apb(1'b0, sleep_pkg::ADDR_STATUS, 32'h0);
			check(rd, {24'h0, 1'b0, md_sel[i], 4'h2});
			if (md_sel[i] != 3'h0) begin
				src[2] <= 1'b1;
				src[3] <= (md_sel[i] == 3'h3);
				global_irq_enable <= 1'b0;
				repeat (10) @(posedge clock);
				check(core_halt, 1'b1);
				src <= 8'h00;
				global_irq_enable <= 1'b1;
			end
			wake(md_src[i], n, rv);
			// Source seen one edge after it rises, start-up, four hold cycles, then pulse
			check(n, md_d[i] + 6);
			check(rv, 1'b0);
			apb(1'b0, sleep_pkg::ADDR_CONTROL, 32'h0);
			check(rd, {24'h0, 1'b1, md_sel[i], 4'h0});
		end
		$display("test modes done");
		as_sel <= 1'b0;
		apb(1'b1, sleep_pkg::ADDR_CONTROL, 32'hA0);
		sleep_now();
		// Pin held low until the core runs again
		wake(6, n, rv);
		check({rv, core_halt}, 2'b00);
		// Two synchroniser stages, six start-up and four hold cycles
		check(n, 32'd14);
		sleep_now();
		wake(7, n, rv);
		check(rv, 1'b1);
		check(n, 32'd12);
		$display("test pin and reset wake done");
		wrap_up();
	end
endmodule
`default_nettype wire
